// File: dpf_top.sv
// Debug pin function select: per-pin settings, pin sharing, low power behaviour
// How it works
// (RULE1) Five debug port pins come out of reset in their debug function.
// (RULE2) Trace clock and trace data pins reset with all settings cleared.
// (RULE3) Mode/data pin resets 1,1,1,1; clock pin function, input, pull-down set.
// (RULE4) Data-out resets function, output, pull-down; data-in and test-reset 1,1,0,1.
// (RULE5) Scan and serial clock share a pin; mode/data share; data-out shares viewer.
// (RULE6) Data-out pin carries viewer output only while the viewer is enabled.
// (RULE7) Mode/data and data-out drivers stay on in first stop mode in debug.
// (RULE8) Watchdog stops while the core is halted; other peripherals keep running.
// (RULE9) A pin switched to port use gives the debug tool no path through it.
// (RULE10) Unused test-reset pin stays in test-reset function, left open or high.
// (RULE11) Supported pin sets: scan+serial, serial, serial+viewer, scan+trace, none.
// (RULE12) Function select 1 routes a pin to debug; 0 gives it to the port.
`timescale 1ns/1ps
module dpf_top #(
  parameter int NPINS = dpf_pkg::NUM_PINS
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // Software settings, write strobe loads all five vectors
  input  wire logic             cfg_write_in,
  input  wire logic [NPINS-1:0] port_function_select_in,
  input  wire logic [NPINS-1:0] port_input_enable_in,
  input  wire logic [NPINS-1:0] port_output_enable_in,
  input  wire logic [NPINS-1:0] port_pull_up_enable_in,
  input  wire logic [NPINS-1:0] port_pull_down_enable_in,
  input  wire logic             serial_viewer_enable_in,
  input  wire logic             standby_drive_enable_in,
  input  wire logic             first_stop_mode_in,
  input  wire logic             core_halted_in,
  // General-purpose port side
  input  wire logic [NPINS-1:0] gpio_out_data_in,
  output logic      [NPINS-1:0] gpio_in_data_out,
  // Debug core side
  input  wire logic             scan_data_out_in,
  input  wire logic             serial_data_drive_in,
  input  wire logic             serial_data_oe_in,
  input  wire logic             serial_trace_viewer_in,
  input  wire logic             trace_clock_in,
  input  wire logic [3:0]       trace_data_in,
  output logic                  debug_clock_out,
  output logic                  mode_data_out,
  output logic                  scan_data_in_out,
  output logic                  test_reset_n_out,
  // Pins: input, output, output enable and pull enables
  input  wire logic [NPINS-1:0] pin_in,
  output logic      [NPINS-1:0] pin_out,
  output logic      [NPINS-1:0] pin_oe_out,
  output logic      [NPINS-1:0] pin_pull_up_out,
  output logic      [NPINS-1:0] pin_pull_down_out,
  // Status
  output logic      [NPINS-1:0] function_select_out,
  output logic                  watchdog_timer_run_out
);
  logic [1:0]       rst_sync;
  logic [1:0]       next_rst_sync;
  logic             rst_n;
  logic [NPINS-1:0] fsel, ien, oen, pup, pdn;
  logic [NPINS-1:0] next_fsel, next_ien, next_oen, next_pup, next_pdn;
  logic [NPINS-1:0] pin_sync;
  logic [NPINS-1:0] drive_val;
  logic [NPINS-1:0] next_pin_out, next_pin_oe, next_gpio_in;
  logic             next_dbg_clk, next_mode_data, next_scan_in, next_trst_n, next_wdt_run;
  logic [1:0]       fill;
  logic [1:0]       next_fill;
  logic             sync_ready;

  // Reset release through two flops
  always_comb begin
    next_rst_sync = {rst_sync[0], 1'b1};
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= next_rst_sync;
    end
  end

  assign rst_n = rst_sync[1];

  // Pin levels and link clock cross into the block clock here
  dpf_sync #(
    .WIDTH (NPINS)
  ) u_pin_sync (
    .clock_in (clock_in),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // Synchroniser fill count after internal reset release
  // Sync stages reset to 0, not every pin's idle level: hold inputs until filled
  always_comb begin
    next_fill = fill;
    if (!sync_ready) begin
      next_fill = fill + 2'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      fill <= 2'h0;
    end else begin
      fill <= next_fill;
    end
  end

  assign sync_ready = (fill == 2'(dpf_pkg::SYNC_STAGES)); // No false test reset after reset

  // Settings: loaded as a group by software
  always_comb begin
    next_fsel = fsel;
    next_ien  = ien;
    next_oen  = oen;
    next_pup  = pup;
    next_pdn  = pdn;
    if (cfg_write_in) begin
      next_fsel = port_function_select_in;
      next_ien  = port_input_enable_in;
      next_oen  = port_output_enable_in;
      next_pup  = port_pull_up_enable_in;
      next_pdn  = port_pull_down_enable_in;
    end
  end

  // Settings registers with documented reset values
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      fsel <= dpf_pkg::RST_FUNCTION;  // RULE1 RULE2 RULE3 RULE4 RULE10
      ien  <= dpf_pkg::RST_INPUT_EN;  // RULE2 RULE3 RULE4
      oen  <= dpf_pkg::RST_OUTPUT_EN; // RULE2 RULE3 RULE4
      pup  <= dpf_pkg::RST_PULL_UP;   // RULE2 RULE3 RULE4
      pdn  <= dpf_pkg::RST_PULL_DOWN; // RULE3 RULE4
    end else begin
      fsel <= next_fsel;
      ien  <= next_ien;
      oen  <= next_oen;
      pup  <= next_pup;
      pdn  <= next_pdn;
    end
  end

  // Debug-side drive value per pin
  always_comb begin
    drive_val = '0;
    drive_val[dpf_pkg::PIN_MODE_DATA] = serial_data_drive_in; // RULE5
    drive_val[dpf_pkg::PIN_DATA_OUT]  = serial_viewer_enable_in ?
                                        serial_trace_viewer_in :
                                        scan_data_out_in; // RULE5 RULE6
    drive_val[dpf_pkg::PIN_TRACE_CLK] = trace_clock_in;
    drive_val[dpf_pkg::PIN_TRACE_D0]  = trace_data_in[0];
    drive_val[dpf_pkg::PIN_TRACE_D1]  = trace_data_in[1];
    drive_val[dpf_pkg::PIN_TRACE_D2]  = trace_data_in[2];
    drive_val[dpf_pkg::PIN_TRACE_D3]  = trace_data_in[3];
  end

  // Pin mux per pin; stop mode gates drivers unless standby drive set or pin is mode/data or data-out in debug use
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      logic keep_on;
      logic stop_off;
      assign keep_on  = fsel[gi] && (gi == dpf_pkg::PIN_MODE_DATA ||
                                     gi == dpf_pkg::PIN_DATA_OUT); // RULE7
      assign stop_off = first_stop_mode_in && !standby_drive_enable_in && !keep_on;
      // Port data or debug data onto the pin
      assign next_pin_out[gi] = fsel[gi] ? drive_val[gi] : gpio_out_data_in[gi]; // RULE12
      // Mode/data pin direction follows the debug core in debug use
      assign next_pin_oe[gi]  = oen[gi] && !stop_off &&
                                (gi != dpf_pkg::PIN_MODE_DATA || !fsel[gi] ||
                                 serial_data_oe_in);
      // Port input path, low until real pin levels arrive
      assign next_gpio_in[gi] = sync_ready && ien[gi] && !fsel[gi] && pin_sync[gi]; // RULE9
    end
  endgenerate

  // Debug inputs: only while the pin is in its debug function
  always_comb begin
    next_dbg_clk   = fsel[dpf_pkg::PIN_CLOCK] && ien[dpf_pkg::PIN_CLOCK] &&
                     pin_sync[dpf_pkg::PIN_CLOCK]; // RULE5 RULE9
    next_mode_data = fsel[dpf_pkg::PIN_MODE_DATA] && ien[dpf_pkg::PIN_MODE_DATA] &&
                     pin_sync[dpf_pkg::PIN_MODE_DATA]; // RULE9
    next_scan_in   = fsel[dpf_pkg::PIN_DATA_IN] && ien[dpf_pkg::PIN_DATA_IN] &&
                     pin_sync[dpf_pkg::PIN_DATA_IN]; // RULE9
    // Test reset idles high when pin is given to the port
    next_trst_n    = !(fsel[dpf_pkg::PIN_TEST_RST] && ien[dpf_pkg::PIN_TEST_RST]) ||
                     pin_sync[dpf_pkg::PIN_TEST_RST]; // RULE9 RULE11
    next_wdt_run   = !core_halted_in; // RULE8
    // Reset levels until the synchroniser has filled
    if (!sync_ready) begin
      next_dbg_clk   = 1'b0;
      next_mode_data = 1'b0;
      next_scan_in   = 1'b0;
      next_trst_n    = 1'b1;
    end
  end

  // Output registers
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_out                <= '0;
      pin_oe_out             <= '0;
      gpio_in_data_out       <= '0;
      debug_clock_out        <= 1'b0;
      mode_data_out          <= 1'b0;
      scan_data_in_out       <= 1'b0;
      test_reset_n_out       <= 1'b1;
      watchdog_timer_run_out <= 1'b1;
    end else begin
      pin_out                <= next_pin_out;
      pin_oe_out             <= next_pin_oe;
      gpio_in_data_out       <= next_gpio_in;
      debug_clock_out        <= next_dbg_clk;
      mode_data_out          <= next_mode_data;
      scan_data_in_out       <= next_scan_in;
      test_reset_n_out       <= next_trst_n;
      watchdog_timer_run_out <= next_wdt_run;
    end
  end

  // Settings shown directly
  assign pin_pull_up_out     = pup;
  assign pin_pull_down_out   = pdn;
  assign function_select_out = fsel;
endmodule : dpf_top

// File: dpf_pkg.sv
// Package of constants for the debug pin function select block
package dpf_pkg;
  // Pin indices of the ten debug-capable pins
  localparam int NUM_PINS      = 10;
  localparam int PIN_MODE_DATA = 0;
  localparam int PIN_CLOCK     = 1;
  localparam int PIN_DATA_OUT  = 2;
  localparam int PIN_DATA_IN   = 3;
  localparam int PIN_TEST_RST  = 4;
  localparam int PIN_TRACE_CLK = 5;
  localparam int PIN_TRACE_D0  = 6;
  localparam int PIN_TRACE_D1  = 7;
  localparam int PIN_TRACE_D2  = 8;
  localparam int PIN_TRACE_D3  = 9;
  // Reset values per pin, bit index is the pin index above
  localparam logic [9:0] RST_FUNCTION   = 10'h01F;
  localparam logic [9:0] RST_INPUT_EN   = 10'h01B;
  localparam logic [9:0] RST_OUTPUT_EN  = 10'h005;
  localparam logic [9:0] RST_PULL_UP    = 10'h019;
  localparam logic [9:0] RST_PULL_DOWN  = 10'h006;
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;
endpackage : dpf_pkg

// File: dpf_sync.sv
// Two-flop synchroniser for a bus of levels from outside the clock domain
`timescale 1ns/1ps
module dpf_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] next_stage_one;
  logic [WIDTH-1:0] next_sync;

  // Next values: first stage read only by second stage
  always_comb begin
    next_stage_one = async_in;
    next_sync      = stage_one;
  end

  // Register both stages
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= next_stage_one;
      sync_out  <= next_sync;
    end
  end
endmodule : dpf_sync

// File: dpf_sva.sv
// Port checker for the debug pin function select block
`timescale 1ns/1ps
module dpf_sva #(
  parameter int NPINS = 10
) (
  input wire logic             clock_in,
  input wire logic             rst_n_in,
  input wire logic             cfg_write_in,
  input wire logic [NPINS-1:0] port_function_select_in,
  input wire logic             serial_viewer_enable_in,
  input wire logic             standby_drive_enable_in,
  input wire logic             first_stop_mode_in,
  input wire logic             core_halted_in,
  input wire logic             scan_data_out_in,
  input wire logic             serial_trace_viewer_in,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe_out,
  input wire logic [NPINS-1:0] pin_pull_up_out,
  input wire logic [NPINS-1:0] pin_pull_down_out,
  input wire logic [NPINS-1:0] function_select_out,
  input wire logic             watchdog_timer_run_out
);
  logic [2:0] up;
  logic [2:0] next_up;
  // Cycles since reset release, saturating once internal reset is long over
  always_comb next_up = (up == 3'h6) ? up : up + 3'h1;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) up <= 3'h0;
    else up <= next_up;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_fsel: assert property ($rose(rst_n_in) |-> function_select_out == 10'h01F)
    else $error("function select reset value wrong");
  a_reset_pulls: assert property ($rose(rst_n_in) |->
    pin_pull_up_out == 10'h019 && pin_pull_down_out == 10'h006) else $error("pull reset wrong");
  a_write_fsel: assert property (up == 3'h6 && cfg_write_in |=>
    function_select_out == $past(port_function_select_in)) else $error("select not loaded");
  a_viewer_route: assert property (up == 3'h6 && function_select_out[2] &&
    serial_viewer_enable_in |=> pin_out[2] == $past(serial_trace_viewer_in))
    else $error("viewer not on pin");
  a_scan_route: assert property (up == 3'h6 && function_select_out[2] &&
    !serial_viewer_enable_in |=> pin_out[2] == $past(scan_data_out_in))
    else $error("scan out not on pin");
  a_stop_keep: assert property (up == 3'h6 && function_select_out[2] &&
    $stable(function_select_out) && !$past(cfg_write_in) |=> $stable(pin_oe_out[2]))
    else $error("data out driver changed");
  a_stop_off: assert property (up == 3'h6 && first_stop_mode_in &&
    !standby_drive_enable_in |=> !pin_oe_out[9]) else $error("trace driver on in stop");
  a_watchdog_halt: assert property (up == 3'h6 |=>
    watchdog_timer_run_out == !$past(core_halted_in)) else $error("watchdog run wrong");
endmodule : dpf_sva
bind dpf_top dpf_sva #(.NPINS(NPINS)) u_sva (.clock_in, .rst_n_in, .cfg_write_in,
  .port_function_select_in, .serial_viewer_enable_in, .standby_drive_enable_in,
  .first_stop_mode_in, .core_halted_in, .scan_data_out_in, .serial_trace_viewer_in, .pin_out,
  .pin_oe_out, .pin_pull_up_out, .pin_pull_down_out, .function_select_out,
  .watchdog_timer_run_out);

// File: dpf_probe.sv
// Debug tool model driving the debug pins from outside
`timescale 1ns/1ps
module dpf_probe (
  input  wire logic       frame_in,
  output logic      [9:0] pins_out
);
  // Eight link clocks per frame, link clock idle low between frames
  initial begin
    pins_out = 10'h018;
    forever begin
      wait (frame_in);
      repeat (8) begin
        #160 pins_out[1:0] = {1'b1, ~pins_out[0]};
        #160 pins_out[1] = 1'b0;
      end
      wait (!frame_in);
    end
  end
endmodule : dpf_probe

// File: debug_pin_function_select_tb.sv
// Self-checking bench for the debug pin function select block
`timescale 1ns/1ps
module debug_pin_function_select_tb;
  logic clock_in = 1'b0, rst_n_in = 1'b0, cfg_write_in = 1'b0, serial_viewer_enable_in = 1'b0;
  logic standby_drive_enable_in = 1'b0, first_stop_mode_in = 1'b0, core_halted_in = 1'b0;
  logic scan_data_out_in = 1'b0, serial_data_drive_in = 1'b0, serial_data_oe_in = 1'b1;
  logic serial_trace_viewer_in = 1'b0, trace_clock_in = 1'b0, frame = 1'b0, last_clk = 1'b0;
  logic [3:0] trace_data_in = 4'h0;
  logic [9:0] port_function_select_in = 10'h000, port_input_enable_in = 10'h000;
  logic [9:0] port_output_enable_in = 10'h000, port_pull_up_enable_in = 10'h000;
  logic [9:0] port_pull_down_enable_in = 10'h000, gpio_out_data_in = 10'h2AA, rises = 10'h000;
  logic [9:0] pin_in, probe_pins, gpio_in_data_out, pin_out, pin_oe_out, pin_pull_up_out;
  logic [9:0] pin_pull_down_out, function_select_out;
  logic debug_clock_out, mode_data_out, scan_data_in_out, test_reset_n_out;
  logic watchdog_timer_run_out;
  int err_total = 0, comparisons = 0, cycles = 0;
  // Design, tool model and the shared pin levels
  dpf_top dut (.clock_in, .rst_n_in, .cfg_write_in, .port_function_select_in,
    .port_input_enable_in, .port_output_enable_in, .port_pull_up_enable_in,
    .port_pull_down_enable_in, .serial_viewer_enable_in, .standby_drive_enable_in,
    .first_stop_mode_in, .core_halted_in, .gpio_out_data_in, .gpio_in_data_out,
    .scan_data_out_in, .serial_data_drive_in, .serial_data_oe_in, .serial_trace_viewer_in,
    .trace_clock_in, .trace_data_in, .debug_clock_out, .mode_data_out, .scan_data_in_out,
    .test_reset_n_out, .pin_in, .pin_out, .pin_oe_out, .pin_pull_up_out, .pin_pull_down_out,
    .function_select_out, .watchdog_timer_run_out);
  dpf_probe probe (.frame_in(frame), .pins_out(probe_pins));
  assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & probe_pins);
  always #20 clock_in = ~clock_in;
  // Link clock edge counter and run time limit
  always @(posedge clock_in) begin
    last_clk <= debug_clock_out;
    if (debug_clock_out & ~last_clk) rises <= rises + 10'h001;
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      end_of_test;
    end
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] fs, input logic [9:0] ie, input logic [9:0] oe,
                    input logic [9:0] pu);
    @(negedge clock_in);
    {port_function_select_in, port_input_enable_in, port_output_enable_in} = {fs, ie, oe};
    {port_pull_up_enable_in, port_pull_down_enable_in} = {pu, ~pu};
    cfg_write_in = 1'b1;
    @(negedge clock_in);
    cfg_write_in = 1'b0;
    repeat (4) @(negedge clock_in);
    chk(function_select_out, fs);
    chk(pin_pull_down_out, ~pu);
  endtask : wr
  task automatic run_frame(input logic [9:0] exp);
    logic [9:0] start;
    start = rises;
    frame = 1'b1;
    repeat (70) @(negedge clock_in);
    frame = 1'b0;
    chk(rises - start, exp);
  endtask : run_frame
  task automatic t_reset;
    chk(function_select_out, 10'h01F);
    chk(pin_pull_up_out, 10'h019);
    chk(pin_pull_down_out, 10'h006);
    chk(pin_oe_out, 10'h005);
    chk({9'h000, test_reset_n_out}, 10'h001);
    chk({9'h000, scan_data_in_out}, 10'h001);
  endtask : t_reset
  task automatic t_view;
    {serial_viewer_enable_in, serial_trace_viewer_in} = 2'h3;
    serial_data_drive_in = 1'b1;
    repeat (2) @(negedge clock_in);
    chk({9'h000, pin_out[2]}, 10'h001);
    serial_viewer_enable_in = 1'b0;
    repeat (2) @(negedge clock_in);
    chk({9'h000, pin_out[2]}, 10'h000);
    chk({9'h000, mode_data_out}, 10'h001);
  endtask : t_view
  task automatic t_port;
    wr(10'h000, 10'h3FF, 10'h000, 10'h000);
    chk(gpio_in_data_out, 10'h018);
    chk(pin_out, 10'h2AA);
    chk({9'h000, scan_data_in_out}, 10'h000);
    run_frame(10'h000);
  endtask : t_port
  task automatic t_stop;
    {trace_clock_in, trace_data_in} = 5'h15;
    wr(10'h3FF, 10'h01B, 10'h3FF, 10'h019);
    chk(pin_out, 10'h161);
    first_stop_mode_in = 1'b1;
    repeat (2) @(negedge clock_in);
    chk(pin_oe_out, 10'h005);
    standby_drive_enable_in = 1'b1;
    repeat (2) @(negedge clock_in);
    chk(pin_oe_out, 10'h3FF);
    {first_stop_mode_in, standby_drive_enable_in} = 2'h0;
  endtask : t_stop
  task automatic t_halt;
    core_halted_in = 1'b1;
    repeat (2) @(negedge clock_in);
    chk({9'h000, watchdog_timer_run_out}, 10'h000);
    core_halted_in = 1'b0;
    repeat (2) @(negedge clock_in);
    chk({9'h000, watchdog_timer_run_out}, 10'h001);
  endtask : t_halt
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Reset, then each scenario in turn
  initial begin
    repeat (5) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (6) @(negedge clock_in);
    t_reset;
    run_frame(10'h008);
    t_view;
    t_port;
    t_stop;
    t_halt;
    end_of_test;
  end
endmodule : debug_pin_function_select_tb
